// [hw/cte_sequencer.v]
/*
  Camera trigger and exposure sequencer: APB register slave, trigger input
  conditioning, clear/expose/transfer/readout sequencing and binning counts.
  Assumes the trigger pin is driven by outside equipment and that all other
  inputs are synchronous to core_clk.
*/
// Summary of operation
// - The trigger pin counts as asserted when it is low.
// - Readout flag is high while a frame is read out, rising and falling one cycle before the shift pulses.
// - Exposure flag is high while the sensor integrates, one pulse per exposure.
// - Internally timed exposures last the programmed exposure count.
// - Clearing mode clears the sensor first, then exposes for the programmed time.
// - After exposure, charge moves to storage at once and readout starts.
// - Clearing mode repeats, each frame beginning with a fresh clear.
// - Overlapped mode skips clearing and exposes next frame during readout.
// - Overlapped timed exposures are stretched to at least the end of readout.
// - Binning merges groups of adjacent pixels, shrinking image and, with row binning, readout time.
// - Setting N by M merges N columns and M rows per output pixel.
// - Edge mode starts on trigger edge, ends after programmed time.
// - Pulse mode integrates while the trigger pulse is asserted, starting after the clear unless overlapped.
// - Continuous mode self-starts, software mode starts on command; both timed.
`timescale 1ns/10ps
`default_nettype none
`include "cte_map.vh"

module cte_sequencer (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        clkEn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        trigInN,
  output reg         readoutOut,
  output reg         exposeOut,
  output reg         clearOut,
  output reg         xferOut,
  output reg         rowShiftOut,
  output reg         pixShiftOut,
  output reg         pixSampleOut
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  reg        enable_r;
  reg [1:0]  mode_r;
  reg        overlap_r;
  reg [31:0] exposeLen_r;
  reg [31:0] clearLen_r;
  reg [31:0] xferLen_r;
  reg [15:0] lines_r;
  reg [15:0] linePix_r;
  reg [3:0]  binH_r;
  reg [3:0]  binV_r;
  reg [31:0] frames_r;
  reg        swTrig_r;
  reg        overrun_r;

  localparam [7:0] BIN_RST = `CTE_RST_BIN;

  wire apbAccess = psel & penable;
  wire apbWrite  = apbAccess & pwrite;
  wire addrHit   = (paddr == `CTE_OFS_CTRL)    | (paddr == `CTE_OFS_EXPOSE) |
                   (paddr == `CTE_OFS_CLEAR)   | (paddr == `CTE_OFS_XFER)   |
                   (paddr == `CTE_OFS_LINES)   | (paddr == `CTE_OFS_LINEPIX) |
                   (paddr == `CTE_OFS_BIN)     | (paddr == `CTE_OFS_STATUS) |
                   (paddr == `CTE_OFS_FRAMES);

  // The slave never stalls; unmapped addresses answer with an error.
  assign pready  = 1'b1;
  assign pslverr = apbAccess & ~addrHit;

  // ****************************************************************
  // Trigger conditioning
  // ****************************************************************
  reg trigMeta_r;
  reg trigSync_r;
  reg trigLast_r;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trigMeta_r <= 1'b0;
      trigSync_r <= 1'b0;
      trigLast_r <= 1'b0;
    end else if (clkEn) begin
      trigMeta_r <= ~trigInN;
      trigSync_r <= trigMeta_r;
      trigLast_r <= trigSync_r;
    end
  end

  wire trigLevel = trigSync_r;
  wire trigRise  = trigSync_r & ~trigLast_r;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_WAIT  = 3'h1;
  localparam [2:0] ST_CLEAR = 3'h2;
  localparam [2:0] ST_EXPO  = 3'h3;
  localparam [2:0] ST_XFER  = 3'h4;

  reg [2:0]  state_r;
  reg [31:0] phaseCnt_r;
  reg        rdActive_r;
  reg [15:0] rowCnt_r;
  reg [15:0] pixCnt_r;
  reg [3:0]  hBinCnt_r;
  reg [3:0]  vBinCnt_r;
  reg        rowPhase_r;

  // Binned readout size: each output row merges binV sensor rows and
  // each output pixel merges binH columns, so fewer samples are taken.
  wire [3:0] binHEff = (binH_r == 4'h0) ? 4'h1 : binH_r;
  wire [3:0] binVEff = (binV_r == 4'h0) ? 4'h1 : binV_r;

  wire startReq = (mode_r == `CTE_MODE_CONT) ? 1'b1 :
                  (mode_r == `CTE_MODE_EDGE) ? trigRise :
                  (mode_r == `CTE_MODE_PULSE) ? trigLevel :
                  swTrig_r;

  wire timedDone = (phaseCnt_r + 32'h1 >= exposeLen_r) &
                   (~overlap_r | ~rdActive_r);
  wire expoDone  = (mode_r == `CTE_MODE_PULSE) ? ~trigLevel : timedDone;

  wire rdLast = rdActive_r & rowPhase_r & (pixCnt_r == 16'h0) &
                (hBinCnt_r == 4'h1) & (rowCnt_r == 16'h1);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r      <= ST_IDLE;
      phaseCnt_r   <= 32'h0;
      exposeOut    <= 1'b0;
      clearOut     <= 1'b0;
      xferOut      <= 1'b0;
      rdActive_r   <= 1'b0;
      readoutOut   <= 1'b0;
      rowCnt_r     <= 16'h0;
      pixCnt_r     <= 16'h0;
      hBinCnt_r    <= 4'h0;
      vBinCnt_r    <= 4'h0;
      rowPhase_r   <= 1'b0;
      rowShiftOut  <= 1'b0;
      pixShiftOut  <= 1'b0;
      pixSampleOut <= 1'b0;
      frames_r     <= 32'h0;
      overrun_r    <= 1'b0;
    end else if (clkEn) begin
      rowShiftOut  <= 1'b0;
      pixShiftOut  <= 1'b0;
      pixSampleOut <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (enable_r) begin
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!enable_r) begin
            state_r <= ST_IDLE;
          end else if (startReq && (overlap_r || !rdActive_r)) begin
            phaseCnt_r <= 32'h0;
            if (overlap_r) begin
              state_r   <= ST_EXPO;
              exposeOut <= 1'b1;
            end else begin
              state_r  <= ST_CLEAR;
              clearOut <= 1'b1;
            end
          end
        end
        ST_CLEAR: begin
          if (phaseCnt_r + 32'h1 >= clearLen_r) begin
            phaseCnt_r <= 32'h0;
            clearOut   <= 1'b0;
            exposeOut  <= 1'b1;
            state_r    <= ST_EXPO;
          end else begin
            phaseCnt_r <= phaseCnt_r + 32'h1;
          end
        end
        ST_EXPO: begin
          if (expoDone) begin
            phaseCnt_r <= 32'h0;
            exposeOut  <= 1'b0;
            xferOut    <= 1'b1;
            state_r    <= ST_XFER;
          end else begin
            phaseCnt_r <= phaseCnt_r + 32'h1;
          end
        end
        ST_XFER: begin
          if (phaseCnt_r + 32'h1 >= xferLen_r) begin
            phaseCnt_r <= 32'h0;
            xferOut    <= 1'b0;
            state_r    <= ST_WAIT;
            if (rdActive_r) begin
              overrun_r <= 1'b1;
            end
          end else begin
            phaseCnt_r <= phaseCnt_r + 32'h1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase

      // Readout engine: starts as soon as the frame sits in storage.
      if (state_r == ST_XFER && phaseCnt_r + 32'h1 >= xferLen_r) begin
        rdActive_r <= 1'b1;
        readoutOut <= 1'b1;
        rowCnt_r   <= lines_r / {12'h0, binVEff};
        vBinCnt_r  <= binVEff;
        rowPhase_r <= 1'b0;
        frames_r   <= frames_r + 32'h1;
      end else if (rdActive_r) begin
        if (!rowPhase_r) begin
          rowShiftOut <= 1'b1;
          if (vBinCnt_r == 4'h1) begin
            rowPhase_r <= 1'b1;
            pixCnt_r   <= linePix_r / {12'h0, binHEff} - 16'h1;
            hBinCnt_r  <= binHEff;
          end else begin
            vBinCnt_r <= vBinCnt_r - 4'h1;
          end
        end else begin
          pixShiftOut <= 1'b1;
          if (hBinCnt_r == 4'h1) begin
            pixSampleOut <= 1'b1;
            hBinCnt_r    <= binHEff;
            if (pixCnt_r == 16'h0) begin
              rowPhase_r <= 1'b0;
              vBinCnt_r  <= binVEff;
              rowCnt_r   <= rowCnt_r - 16'h1;
            end else begin
              pixCnt_r <= pixCnt_r - 16'h1;
            end
          end else begin
            hBinCnt_r <= hBinCnt_r - 4'h1;
          end
        end
        if (rdLast || rowCnt_r == 16'h0) begin
          rdActive_r <= 1'b0;
          readoutOut <= 1'b0;
        end
      end
      if (apbWrite && paddr == `CTE_OFS_STATUS && pwdata[1]) begin
        if (!(state_r == ST_XFER && rdActive_r && phaseCnt_r + 32'h1 >= xferLen_r)) begin
          overrun_r <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // APB write and read
  // ****************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enable_r    <= 1'b0;
      mode_r      <= `CTE_MODE_CONT;
      overlap_r   <= 1'b0;
      exposeLen_r <= `CTE_RST_EXPOSE;
      clearLen_r  <= `CTE_RST_CLEAR;
      xferLen_r   <= `CTE_RST_XFER;
      lines_r     <= `CTE_RST_LINES;
      linePix_r   <= `CTE_RST_LINEPIX;
      binH_r      <= BIN_RST[3:0];
      binV_r      <= BIN_RST[7:4];
      swTrig_r    <= 1'b0;
    end else if (clkEn) begin
      // Software trigger is held until the sequencer waits with no readout active.
      if (swTrig_r && state_r == ST_WAIT && !rdActive_r) begin
        swTrig_r <= 1'b0;
      end
      if (apbWrite) begin
        case (paddr)
          `CTE_OFS_CTRL: begin
            enable_r  <= pwdata[`CTE_CTRL_EN];
            mode_r    <= pwdata[`CTE_CTRL_MODE_HI:`CTE_CTRL_MODE_LO];
            overlap_r <= pwdata[`CTE_CTRL_OVLP];
            if (pwdata[`CTE_CTRL_SWTRIG]) begin
              swTrig_r <= 1'b1;
            end
          end
          `CTE_OFS_EXPOSE:  exposeLen_r <= pwdata;
          `CTE_OFS_CLEAR:   clearLen_r  <= pwdata;
          `CTE_OFS_XFER:    xferLen_r   <= pwdata;
          `CTE_OFS_LINES:   lines_r     <= pwdata[15:0];
          `CTE_OFS_LINEPIX: linePix_r   <= pwdata[15:0];
          `CTE_OFS_BIN: begin
            binH_r <= pwdata[3:0];
            binV_r <= pwdata[7:4];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Read data is loaded in the setup cycle so that it already stands in the
  // access phase; a zero-wait slave has no later edge to present it on.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (clkEn && psel && !penable && !pwrite) begin
      case (paddr)
        `CTE_OFS_CTRL:    prdata <= {27'h0, swTrig_r, overlap_r, mode_r, enable_r};
        `CTE_OFS_EXPOSE:  prdata <= exposeLen_r;
        `CTE_OFS_CLEAR:   prdata <= clearLen_r;
        `CTE_OFS_XFER:    prdata <= xferLen_r;
        `CTE_OFS_LINES:   prdata <= {16'h0, lines_r};
        `CTE_OFS_LINEPIX: prdata <= {16'h0, linePix_r};
        `CTE_OFS_BIN:     prdata <= {24'h0, binV_r, binH_r};
        `CTE_OFS_STATUS:  prdata <= {24'h0, trigLevel, state_r, exposeOut,
                                     readoutOut, overrun_r, rdActive_r};
        `CTE_OFS_FRAMES:  prdata <= frames_r;
        default:          prdata <= 32'h0;
      endcase
    end
  end

endmodule

`default_nettype wire

// [pkg/cte_map.vh]
/*
  Register offsets, field positions, reset values and timing counts of the
  camera trigger and exposure sequencer.
  Assumes inclusion by bare name from design files under hw/.
*/
`ifndef CTE_MAP_VH
`define CTE_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CTE_OFS_CTRL      12'h000
`define CTE_OFS_EXPOSE    12'h004
`define CTE_OFS_CLEAR     12'h008
`define CTE_OFS_XFER      12'h00C
`define CTE_OFS_LINES     12'h010
`define CTE_OFS_LINEPIX   12'h014
`define CTE_OFS_BIN       12'h018
`define CTE_OFS_STATUS    12'h01C
`define CTE_OFS_FRAMES    12'h020

// ****************************************************************
// Control field positions
// ****************************************************************
`define CTE_CTRL_EN       0
`define CTE_CTRL_MODE_LO  1
`define CTE_CTRL_MODE_HI  2
`define CTE_CTRL_OVLP     3
`define CTE_CTRL_SWTRIG   4

// ****************************************************************
// Trigger modes
// ****************************************************************
`define CTE_MODE_CONT     2'h0
`define CTE_MODE_EDGE     2'h1
`define CTE_MODE_PULSE    2'h2
`define CTE_MODE_SOFT     2'h3

// ****************************************************************
// Reset values; exposure, clear and transfer counts in core clock cycles
// ****************************************************************
`define CTE_RST_EXPOSE    32'h0000_0400
`define CTE_RST_CLEAR     32'h0000_0040
`define CTE_RST_XFER      32'h0000_0020
`define CTE_RST_LINES     16'h0010
`define CTE_RST_LINEPIX   16'h0010
`define CTE_RST_BIN       8'h11

`endif

// [test/cte_seq_checker.sv]
/*
  Port assertions of the trigger and exposure sequencer.
  Assumes one clock domain and a reset before every scenario.
*/
`timescale 1ns/10ps
`default_nettype none
module cte_seq_checker (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        readoutOut,
  input wire logic        exposeOut,
  input wire logic        clearOut,
  input wire logic        xferOut
);
  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ********************************
  // Bus and frame sequence
  // ********************************
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("access without ready");
  bad_addr_a: assert property (psel && penable && paddr > 12'h020 |-> pslverr)
    else $error("unmapped address not refused");
  idle_err_a: assert property (!psel |-> !pslverr)
    else $error("error flag outside a transfer");
  clear_first_a: assert property ($fell(clearOut) |-> exposeOut)
    else $error("exposure does not follow clear");
  clear_excl_a: assert property (!(clearOut && exposeOut))
    else $error("clear during exposure");
  expose_xfer_a: assert property ($fell(exposeOut) |-> xferOut)
    else $error("no transfer after exposure");
  xfer_read_a: assert property ($fell(xferOut) |-> readoutOut [*2])
    else $error("no readout after transfer");
  read_src_a: assert property ($rose(readoutOut) |-> $past(xferOut))
    else $error("readout without transfer");
endmodule
bind cte_sequencer cte_seq_checker u_chk (.*);
`default_nettype wire

// [test/cte_sequencer_bench.sv]
/*
  Self-checking bench of the trigger and exposure sequencer.
  Assumes cte_map.vh on the include path and the checker bound.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cte_map.vh"
module cte_sequencer_bench;
  logic        core_clk;
  logic        rst;
  logic        clkEn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trigInN;
  logic        readoutOut;
  logic        exposeOut;
  logic        clearOut;
  logic        xferOut;
  logic        rowShiftOut;
  logic        pixShiftOut;
  logic        pixSampleOut;
  logic [3:0]  ph;
  logic        err;
  int          miscompares;
  int          n_compared;
  int          nRow;
  int          nPix;
  int          nSmp;
  int          nClr;
  int          nBoth;
  int          eCnt;
  int          rCnt;
  int          lastE;
  int          lastR;
  assign ph = {readoutOut, xferOut, exposeOut, clearOut};
  cte_sequencer u_cte_sequencer (.core_clk(core_clk), .rst(rst), .clkEn(clkEn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .trigInN(trigInN),
    .readoutOut(readoutOut), .exposeOut(exposeOut), .clearOut(clearOut),
    .xferOut(xferOut), .rowShiftOut(rowShiftOut), .pixShiftOut(pixShiftOut),
    .pixSampleOut(pixSampleOut));
  cte_trig_model u_cte_trig_model (.core_clk(core_clk), .exposeOut(exposeOut),
    .trigInN(trigInN));
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  // Outputs are counted on the falling edge, where they stand settled, so the
  // scenario tasks can read the totals at a rising edge without a race.
  always @(negedge core_clk) begin
    nRow += rowShiftOut;
    nPix += pixShiftOut;
    nSmp += pixSampleOut;
    nClr += clearOut;
    nBoth += exposeOut && readoutOut;
    if (!exposeOut && eCnt > 0) lastE = eCnt;
    eCnt = exposeOut ? eCnt + 1 : 0;
    if (!readoutOut && rCnt > 0) lastR = rCnt;
    rCnt = readoutOut ? rCnt + 1 : 0;
  end
  // ********************************
  // Shared tasks
  // ********************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Read data and the error flag are taken at the edge that ends the access; an
  // idle edge follows so that back-to-back calls never assign psel twice at once.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    err = pslverr;
    q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'h0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic cfg(input logic [31:0] e, input logic [31:0] n, input logic [31:0] b,
                     input logic [31:0] ctl);
    logic [31:0] q;
    rst <= 1'h1;
    @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    apb(1'h1, `CTE_OFS_EXPOSE, e, q);
    apb(1'h1, `CTE_OFS_CLEAR, 32'h4, q);
    apb(1'h1, `CTE_OFS_XFER, 32'h3, q);
    apb(1'h1, `CTE_OFS_LINES, n, q);
    apb(1'h1, `CTE_OFS_LINEPIX, n, q);
    apb(1'h1, `CTE_OFS_BIN, b, q);
    apb(1'h1, `CTE_OFS_CTRL, ctl, q);
  endtask
  task automatic width(input int i, output int w);
    int t;
    t = 0;
    w = 0;
    while (ph[i] !== 1'h1 && t < 2000) begin
      @(posedge core_clk);
      t++;
    end
    while (ph[i] === 1'h1) begin
      @(posedge core_clk);
      w++;
    end
  endtask
  // ********************************
  // Scenarios
  // ********************************
  task automatic t_regs;
    rdc(`CTE_OFS_EXPOSE, `CTE_RST_EXPOSE);
    rdc(`CTE_OFS_CLEAR, `CTE_RST_CLEAR);
    rdc(`CTE_OFS_XFER, `CTE_RST_XFER);
    rdc(`CTE_OFS_BIN, {24'h0, `CTE_RST_BIN});
    rdc(12'h100, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("registers done");
  endtask
  task automatic t_clear;
    int w;
    int r;
    int s;
    int p;
    cfg(32'h6, 32'h2, 32'h11, 32'h1);
    width(0, w);
    chk(w, 4);
    width(1, w);
    chk(w, 6);
    width(2, w);
    chk(w, 3);
    r = nRow;
    s = nSmp;
    p = nPix;
    width(3, w);
    chk(w, 6);
    chk(nRow - r, 2);
    chk(nSmp - s, 4);
    chk(nPix - p, 4);
    width(0, w);
    chk(w, 4);
    rdc(`CTE_OFS_FRAMES, 32'h1);
    $display("clearing mode done");
  endtask
  task automatic t_bin;
    int w;
    int r;
    int s;
    cfg(32'h6, 32'h4, 32'h22, 32'h1);
    width(2, w);
    r = nRow;
    s = nSmp;
    width(3, w);
    chk(w, 12);
    chk(nRow - r, 4);
    chk(nSmp - s, 4);
    $display("binning done");
  endtask
  task automatic t_ovlp;
    int w;
    int c;
    int b;
    cfg(32'h2, 32'h2, 32'h11, 32'h9);
    c = nClr;
    b = nBoth;
    width(3, w);
    width(2, w);
    chk(nClr - c, 0);
    chk(nBoth > b, 1);
    chk(lastE >= lastR, 1);
    $display("overlap mode done");
  endtask
  task automatic t_trig;
    int w;
    int sh;
    cfg(32'h28, 32'h2, 32'h11, 32'hB);
    repeat (20) @(posedge core_clk);
    chk(exposeOut, 1'h0);
    u_cte_trig_model.pulse(2);
    width(1, w);
    chk(w, 40);
    width(3, w);
    u_cte_trig_model.pulse(2);
    width(1, w);
    chk(w, 40);
    cfg(32'h4, 32'h2, 32'h11, 32'hD);
    sh = u_cte_trig_model.shutterCycles;
    fork
      u_cte_trig_model.pulse(12);
      width(1, w);
    join
    chk(w, 12);
    chk(u_cte_trig_model.shutterCycles - sh, 12);
    $display("trigger modes done");
  endtask
  task automatic t_soft;
    int w;
    logic [31:0] q;
    cfg(32'h5, 32'h2, 32'h11, 32'h7);
    repeat (20) @(posedge core_clk);
    chk(clearOut | exposeOut, 1'h0);
    apb(1'h1, `CTE_OFS_CTRL, 32'h17, q);
    width(0, w);
    chk(w, 4);
    width(1, w);
    chk(w, 5);
    width(3, w);
    apb(1'h1, `CTE_OFS_CTRL, 32'h17, q);
    width(0, w);
    fork
      width(1, w);
      begin
        @(posedge core_clk);
        clkEn <= 1'h0;
        repeat (3) @(posedge core_clk);
        clkEn <= 1'h1;
      end
    join
    chk(w, 8);
    $display("software trigger done");
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    conclude;
  end
  initial begin
    rst = 1'h1;
    clkEn = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    t_regs;
    t_clear;
    t_bin;
    t_ovlp;
    t_trig;
    t_soft;
    conclude;
  end
endmodule
`default_nettype wire

// [test/cte_trig_model.sv]
/*
  Outside trigger source: idles high, drives active-low pulses.
  Assumes calls just after a rising edge of core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module cte_trig_model (
  input  wire logic core_clk,
  input  wire logic exposeOut,
  output var  logic trigInN
);
  int shutterCycles;
  initial trigInN = 1'h1;
  // The outside shutter is open for every cycle that the exposure pulse
  // stands; counting on the falling edge keeps clear of the launching edge.
  always @(negedge core_clk) begin
    if (exposeOut === 1'h1) shutterCycles++;
  end
  // The pulse length is what sets the exposure in pulse-width mode.
  task automatic pulse(input int n);
    trigInN <= 1'h0;
    repeat (n) @(posedge core_clk);
    trigInN <= 1'h1;
  endtask
endmodule
`default_nettype wire
